// ==== hdl/adcsc_apb_port.sv ====
// apb slave handshake: one wait state, error on unmapped word
// assumes a master that holds its request until pready
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_defs.svh"
module adcsc_apb_port (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire adcsc_pkg::adcsc_apb_req_t req,
    output logic                          pready,
    output logic                          pslverr,
    output logic [7:0]                    idx,
    output logic                          fetch,
    output logic                          acc
);
    import adcsc_pkg::*;

    logic mapped;
    logic next_pready;
    logic next_pslverr;

    // decode; upper address bits and misaligned words are unmapped
    always_comb begin
        idx   = req.paddr[9:2];
        fetch = req.psel & req.penable & ~pready;
        acc   = req.psel & req.penable & pready & ~pslverr;
        case (idx)
            `ADCSC_IDX_PORT, `ADCSC_IDX_IRQ_FLAGS, `ADCSC_IDX_RES_HI,
            `ADCSC_IDX_CTRL, `ADCSC_IDX_IRQ_EN, `ADCSC_IDX_ACQ,
            `ADCSC_IDX_RES_LO, `ADCSC_IDX_CFG: mapped = 1'b1;
            default:                           mapped = 1'b0;
        endcase
        mapped       = mapped & (req.paddr[11:10] == 2'h0) & (req.paddr[1:0] == 2'h0);
        next_pready  = fetch;
        next_pslverr = fetch & ~mapped;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/adcsc_defs.svh ====
// register indices, field positions, reset values and counts for the
// converter sequencing block; included by every design file that needs them
`ifndef ADCSC_DEFS_SVH
`define ADCSC_DEFS_SVH

// register indices, byte address is four times the index
`define ADCSC_IDX_PORT      8'h05
`define ADCSC_IDX_IRQ_FLAGS 8'h0c
`define ADCSC_IDX_RES_HI    8'h1e
`define ADCSC_IDX_CTRL      8'h1f
`define ADCSC_IDX_IRQ_EN    8'h8c
`define ADCSC_IDX_ACQ       8'h9d
`define ADCSC_IDX_RES_LO    8'h9e
`define ADCSC_IDX_CFG       8'h9f

// field positions
`define ADCSC_CTRL_ON       0
`define ADCSC_CTRL_GO       2
`define ADCSC_CTRL_CSEL_LO  7:6
`define ADCSC_CFG_JUSTIFY   7
`define ADCSC_CFG_CSEL_HI   6
`define ADCSC_CFG_PINS      3:0
`define ADCSC_ACQ_SEL       5:3
`define ADCSC_DONE_BIT      6

// reset values
`define ADCSC_RST_BYTE      8'h00

// codes
`define ADCSC_ACQ_NONE      3'h0
`define ADCSC_CSEL_RC       2'h3
`define ADCSC_TRIG_MODE     4'hb
`define ADCSC_PORT_ALL      8'hff

// counts in clock cycles or conversion bit periods
`define ADCSC_TCY_CLKS      3'h4
`define ADCSC_CONV_TADS     5'h0c
`define ADCSC_HOLD_TADS     5'h02
// acquisition periods per select code, code 7 first
`define ADCSC_ACQ_TABLE {5'h14, 5'h10, 5'h0c, 5'h08, 5'h06, 5'h04, 5'h02, 5'h00}
// oscillator periods per clock select code, code 7 first, rc codes unused
`define ADCSC_DIV_TABLE {7'h00, 7'h40, 7'h10, 7'h04, 7'h00, 7'h20, 7'h08, 7'h02}

`endif

// ==== hdl/adcsc_pkg.sv ====
// types shared by the converter sequencing block
// assumes the defs header is included by the files that use the numbers
package adcsc_pkg;

    // one apb request as the master drives it
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } adcsc_apb_req_t;

    // analog front-end controls
    typedef struct packed {
        logic powered;
        logic sample_connect;
        logic converting;
    } adcsc_analog_t;

    typedef enum logic [2:0] {
        SEQ_SAMPLE,
        SEQ_START_DLY,
        SEQ_ACQ,
        SEQ_CONV,
        SEQ_HOLD
    } adcsc_state_t;

endpackage

// ==== hdl/adcsc_tad_gen.sv ====
// conversion bit period tick generator
// assumes rc_tick is a one-cycle pulse synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_defs.svh"
module adcsc_tad_gen (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] csel,
    input  wire logic       rc_tick,
    input  wire logic       run,
    output logic            tad_tick
);
    import adcsc_pkg::*;

    localparam logic [55:0] DIV_TBL = `ADCSC_DIV_TABLE;

    logic [6:0] div_cnt;
    logic [6:0] next_div_cnt;
    logic [6:0] period;
    logic       next_tad_tick;

    // divider restarts whenever the sequencer idles, so phase is per start
    always_comb begin
        period        = DIV_TBL[int'(csel) * 7 +: 7];
        next_div_cnt  = div_cnt;
        next_tad_tick = 1'b0;
        if (!run) begin
            next_div_cnt = 7'h00;
        end else if (csel[1:0] == `ADCSC_CSEL_RC) begin
            next_tad_tick = rc_tick;
        end else if (div_cnt == period - 7'h01) begin
            next_div_cnt  = 7'h00;
            next_tad_tick = 1'b1;
        end else begin
            next_div_cnt = div_cnt + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt  <= 7'h00;
            tad_tick <= 1'b0;
        end else begin
            div_cnt  <= next_div_cnt;
            tad_tick <= next_tad_tick;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/adcsc_top.sv ====
// converter sequencing control: registers, start/abort, acquisition,
// conversion timing, sleep handling and compare trigger
// assumes synchronous inputs and an external sar core giving sar_result
//
// Behaviour
// - acquisition select 000: conversion starts one instruction cycle late
// - port reads of analog-configured pins return zero
// - clearing go during a conversion aborts it at once
// - abort leaves the result pair untouched
// - after completion or abort wait 2 bit periods, then sample again
// - select 010 acquires 4 bit periods, then converts automatically
// - sleep conversion works only with the rc conversion clock
// - rc clock: wait one instruction cycle before converting
// - sleep completion: clear go, load result, wake or power down
// - sleep with non-rc clock aborts and powers down, on bit kept
// - reset disables converter, aborts, makes every input pin analog
// - result high byte has no reset value
// - trigger in mode 1011 with converter on sets go, clears timer
// - converter off: trigger ignored but timer still cleared
// - acquisition bits 5:3; clock select split over config and control
// - completion loads result, clears go, sets done flag
// - clock select codes map to 2..64 oscillator periods or rc
// - a conversion takes 12 bit periods
// - nonzero acquisition select samples then converts unaided
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_defs.svh"
module adcsc_top (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire adcsc_pkg::adcsc_apb_req_t apb_req,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [9:0]               sar_result,
    input  wire logic                     rc_tick,
    input  wire logic                     sleep_req,
    input  wire logic [3:0]               compare_mode_sel,
    input  wire logic                     special_trigger,
    input  wire logic [7:0]               port_pins,
    output var adcsc_pkg::adcsc_analog_t  analog,
    output logic                          wake_req,
    output logic                          timer_clear
);
    import adcsc_pkg::*;

    localparam logic [39:0] ACQ_TBL = `ADCSC_ACQ_TABLE;

    // register file
    logic [7:0]    ctrl, cfg, acq_cfg, flags, ien, result_high, result_low;
    logic [7:0]    next_ctrl, next_cfg, next_acq, next_flags, next_ien;
    logic [7:0]    next_res_hi, next_res_lo, rdata;
    logic [31:0]   next_prdata;
    logic          pdown, next_pdown, next_wake, next_tclr;
    // sequencer
    adcsc_state_t  state, next_state;
    logic [4:0]    tad_cnt, next_tad_cnt;
    logic [2:0]    dly_cnt, next_dly_cnt;
    adcsc_analog_t next_analog;
    // bus and events
    logic [7:0]    idx;
    logic          fetch, acc, wr, tad_tick, tad_run;
    logic [2:0]    csel, acq_sel;
    logic [4:0]    acq_tads;
    logic          rc_sel, busy, trig_hit, start, done, abort;
    logic          wr_ctrl, sw_abort, sleep_abort, off_abort;

    adcsc_apb_port u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .req     (apb_req),
        .pready  (pready),
        .pslverr (pslverr),
        .idx     (idx),
        .fetch   (fetch),
        .acc     (acc)
    );

    adcsc_tad_gen u_tad (
        .pclk     (pclk),
        .presetn  (presetn),
        .csel     (csel),
        .rc_tick  (rc_tick),
        .run      (tad_run),
        .tad_tick (tad_tick)
    );

    // field extraction and sequencing events
    always_comb begin
        csel        = {cfg[`ADCSC_CFG_CSEL_HI], ctrl[`ADCSC_CTRL_CSEL_LO]};
        acq_sel     = acq_cfg[`ADCSC_ACQ_SEL];
        acq_tads    = ACQ_TBL[int'(acq_sel) * 5 +: 5];
        rc_sel      = (csel[1:0] == `ADCSC_CSEL_RC);
        busy        = (state == SEQ_START_DLY) | (state == SEQ_ACQ) | (state == SEQ_CONV);
        tad_run     = (state == SEQ_ACQ) | (state == SEQ_CONV) | (state == SEQ_HOLD);
        wr          = acc & apb_req.pwrite;
        wr_ctrl     = wr & (idx == `ADCSC_IDX_CTRL);
        trig_hit    = special_trigger & (compare_mode_sel == `ADCSC_TRIG_MODE);
        // go write only counts if the converter was already on
        start       = (state == SEQ_SAMPLE) & ctrl[`ADCSC_CTRL_ON] & ~pdown
                    & ((wr_ctrl & apb_req.pwdata[`ADCSC_CTRL_GO]) | trig_hit);
        done        = (state == SEQ_CONV) & tad_tick
                    & (tad_cnt == `ADCSC_CONV_TADS - 5'h01);
        sw_abort    = wr_ctrl & ~apb_req.pwdata[`ADCSC_CTRL_GO];
        off_abort   = wr_ctrl & ~apb_req.pwdata[`ADCSC_CTRL_ON];
        sleep_abort = sleep_req & ~rc_sel & busy;
        abort       = busy & ~done & (sw_abort | off_abort | sleep_abort);
    end

    // sequencer next state
    always_comb begin
        next_state   = state;
        next_tad_cnt = tad_cnt;
        next_dly_cnt = dly_cnt;
        case (state)
            SEQ_SAMPLE: begin
                next_tad_cnt = 5'h00;
                next_dly_cnt = 3'h0;
                if (start) begin
                    // no programmed acquisition or rc clock: one instruction cycle
                    if (acq_sel == `ADCSC_ACQ_NONE || rc_sel) begin
                        next_state = SEQ_START_DLY;
                    end else begin
                        next_state = SEQ_ACQ;
                    end
                end
            end
            SEQ_START_DLY: begin
                next_dly_cnt = dly_cnt + 3'h1;
                if (dly_cnt == `ADCSC_TCY_CLKS - 3'h1) begin
                    next_state = (acq_sel == `ADCSC_ACQ_NONE) ? SEQ_CONV : SEQ_ACQ;
                end
            end
            SEQ_ACQ: begin
                if (tad_tick) begin
                    next_tad_cnt = tad_cnt + 5'h01;
                    if (tad_cnt == acq_tads - 5'h01) begin
                        next_tad_cnt = 5'h00;
                        next_state   = SEQ_CONV;
                    end
                end
            end
            SEQ_CONV: begin
                if (tad_tick) begin
                    next_tad_cnt = tad_cnt + 5'h01;
                end
                if (done) begin
                    next_tad_cnt = 5'h00;
                    next_state   = SEQ_HOLD;
                end
            end
            SEQ_HOLD: begin
                if (tad_tick) begin
                    next_tad_cnt = tad_cnt + 5'h01;
                    if (tad_cnt == `ADCSC_HOLD_TADS - 5'h01) begin
                        next_state = SEQ_SAMPLE;
                    end
                end
            end
            default: begin
                next_state = SEQ_SAMPLE;
            end
        endcase
        if (abort) begin
            next_state   = SEQ_HOLD;
            next_tad_cnt = 5'h00;
        end
    end

    // registers, go flag, sleep power state, trigger timer clear
    always_comb begin
        next_ctrl  = ctrl;
        next_cfg   = cfg;
        next_acq   = acq_cfg;
        next_flags = flags;
        next_ien   = ien;
        if (wr) begin
            case (idx)
                // go is owned by the sequencer, not stored from the write
                `ADCSC_IDX_CTRL: next_ctrl = {apb_req.pwdata[7:3], ctrl[`ADCSC_CTRL_GO],
                                              apb_req.pwdata[1:0]};
                `ADCSC_IDX_CFG:       next_cfg   = apb_req.pwdata[7:0];
                `ADCSC_IDX_ACQ:       next_acq   = apb_req.pwdata[7:0];
                `ADCSC_IDX_IRQ_FLAGS: next_flags = apb_req.pwdata[7:0];
                `ADCSC_IDX_IRQ_EN:    next_ien   = apb_req.pwdata[7:0];
                default:              next_ctrl  = ctrl;
            endcase
        end
        if (start) begin
            next_ctrl[`ADCSC_CTRL_GO] = 1'b1;
        end
        if (done || abort) begin
            next_ctrl[`ADCSC_CTRL_GO] = 1'b0;
        end
        if (done) begin
            next_flags[`ADCSC_DONE_BIT] = 1'b1;
        end
        // powered-down state ends when the core leaves sleep
        next_pdown = pdown & sleep_req;
        if (sleep_abort || (done && sleep_req && !ien[`ADCSC_DONE_BIT])) begin
            next_pdown = 1'b1;
        end
        next_wake = done & sleep_req & ien[`ADCSC_DONE_BIT];
        next_tclr = trig_hit;
    end

    // read mux; analog pins read low on the port
    always_comb begin
        case (idx)
            `ADCSC_IDX_PORT:      rdata = port_pins
                                        & ~(`ADCSC_PORT_ALL >> cfg[`ADCSC_CFG_PINS]);
            `ADCSC_IDX_IRQ_FLAGS: rdata = flags;
            `ADCSC_IDX_RES_HI:    rdata = result_high;
            `ADCSC_IDX_CTRL:      rdata = ctrl;
            `ADCSC_IDX_IRQ_EN:    rdata = ien;
            `ADCSC_IDX_ACQ:       rdata = acq_cfg & 8'h38;
            `ADCSC_IDX_RES_LO:    rdata = result_low;
            `ADCSC_IDX_CFG:       rdata = cfg;
            default:              rdata = `ADCSC_RST_BYTE;
        endcase
        next_prdata = prdata;
        if (fetch && !apb_req.pwrite) begin
            next_prdata = {24'h00_0000, rdata};
        end
        next_analog.powered        = next_ctrl[`ADCSC_CTRL_ON] & ~next_pdown;
        next_analog.sample_connect = (next_state == SEQ_SAMPLE) | (next_state == SEQ_START_DLY)
                                   | (next_state == SEQ_ACQ);
        next_analog.converting     = (next_state == SEQ_CONV);
    end

    // result pair: hardware load beats a software write in the same cycle
    always_comb begin
        next_res_hi = result_high;
        next_res_lo = result_low;
        if (wr && idx == `ADCSC_IDX_RES_HI) begin
            next_res_hi = apb_req.pwdata[7:0];
        end
        if (wr && idx == `ADCSC_IDX_RES_LO) begin
            next_res_lo = apb_req.pwdata[7:0];
        end
        if (done) begin
            if (cfg[`ADCSC_CFG_JUSTIFY]) begin
                next_res_hi = {6'h00, sar_result[9:8]};
                next_res_lo = sar_result[7:0];
            end else begin
                next_res_hi = sar_result[9:2];
                next_res_lo = {sar_result[1:0], 6'h00};
            end
        end
    end

    // result has no reset: unknown after power-on
    always_ff @(posedge pclk) begin
        result_high <= next_res_hi;
        result_low  <= next_res_lo;
    end

    // control state; reset turns the converter off and pins analog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl        <= `ADCSC_RST_BYTE;
            cfg         <= `ADCSC_RST_BYTE;
            acq_cfg     <= `ADCSC_RST_BYTE;
            flags       <= `ADCSC_RST_BYTE;
            ien         <= `ADCSC_RST_BYTE;
            pdown       <= 1'b0;
            wake_req    <= 1'b0;
            timer_clear <= 1'b0;
            prdata      <= 32'h0000_0000;
            state       <= SEQ_SAMPLE;
            tad_cnt     <= 5'h00;
            dly_cnt     <= 3'h0;
            analog      <= '0;
        end else begin
            ctrl        <= next_ctrl;
            cfg         <= next_cfg;
            acq_cfg     <= next_acq;
            flags       <= next_flags;
            ien         <= next_ien;
            pdown       <= next_pdown;
            wake_req    <= next_wake;
            timer_clear <= next_tclr;
            prdata      <= next_prdata;
            state       <= next_state;
            tad_cnt     <= next_tad_cnt;
            dly_cnt     <= next_dly_cnt;
            analog      <= next_analog;
        end
    end

    // checks: helper counts bit periods spent in the current state
    logic [4:0] hlp_ticks;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hlp_ticks <= 5'h00;
        end else if (state != next_state) begin
            hlp_ticks <= 5'h00;
        end else if (tad_tick) begin
            hlp_ticks <= hlp_ticks + 5'h01;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_DONE_EFFECTS: assert property (done |=> !ctrl[`ADCSC_CTRL_GO] && flags[`ADCSC_DONE_BIT])
        else $error("completion did not clear go or set done flag");
    AST_ABORT_KEEPS_RESULT: assert property (abort |=> $stable(result_high))
        else $error("aborted conversion changed the result");
    AST_SW_ABORT: assert property (busy && sw_abort && !done |=> state == SEQ_HOLD && !ctrl[2])
        else $error("software clear did not abort");
    AST_START_DELAY: assert property ($rose(state == SEQ_START_DLY) && !abort
        |-> (state == SEQ_START_DLY)[*4] ##1 state != SEQ_START_DLY)
        else $error("start delay not one instruction cycle");
    AST_CONV_LENGTH: assert property (done |-> hlp_ticks == 5'd11)
        else $error("conversion not 12 bit periods");
    AST_HOLD_LENGTH: assert property (state == SEQ_HOLD && next_state == SEQ_SAMPLE
        |-> hlp_ticks == 5'd1)
        else $error("post-conversion wait not 2 bit periods");
    AST_TRIG_TIMER: assert property (trig_hit |=> timer_clear)
        else $error("trigger did not clear timer");
    AST_TRIG_OFF: assert property (trig_hit && !ctrl[0] && state == SEQ_SAMPLE
        |=> state == SEQ_SAMPLE && !ctrl[2])
        else $error("trigger started a conversion while off");
    AST_TRIG_ON: assert property (trig_hit && ctrl[0] && !pdown && state == SEQ_SAMPLE
        && !wr_ctrl |=> ctrl[2])
        else $error("trigger did not set go");
    AST_SLEEP_ABORT: assert property (sleep_abort && !off_abort |=> !analog.powered && ctrl[0])
        else $error("sleep abort did not power down");
    AST_SLEEP_WAKE: assert property (done && sleep_req && ien[6] |=> wake_req)
        else $error("no wake after sleep completion");
    AST_PORT_ZERO: assert property (fetch && !apb_req.pwrite && idx == `ADCSC_IDX_PORT
        && cfg[`ADCSC_CFG_PINS] == 4'h0 |=> prdata == 32'h0000_0000)
        else $error("analog pin read nonzero");

    COV_COMPLETE: cover property (done);
    COV_ABORT: cover property (abort);
    COV_TRIG_START: cover property (trig_hit && start);
    COV_SLEEP_WAKE: cover property (done && sleep_req && ien[6]);
endmodule
`default_nettype wire

// ==== testbench/adc_sequencing_control_tb_top.sv ====
// self-checking bench for the converter sequencing block over apb
// assumes the defs header and package are compiled ahead of it
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_defs.svh"
module adc_sequencing_control_tb_top;
    import adcsc_pkg::*;
    logic           pclk = 1'b0;
    logic           presetn = 1'b0;
    adcsc_apb_req_t apb_req = '0;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic [9:0]     sar_result = 10'h2d5;
    logic           rc_tick = 1'b0;
    logic           sleep_req = 1'b0;
    logic [3:0]     compare_mode_sel = 4'hb;
    logic           special_trigger = 1'b0;
    logic [7:0]     port_pins = 8'h5a;
    adcsc_analog_t  analog;
    logic           wake_req;
    logic           timer_clear;
    logic           woke = 1'b0;
    logic [2:0]     rc_cnt = 3'h0;
    logic [31:0]    rd_val;
    logic           err_seen;
    int             num_errors = 0;
    int             checks = 0;

    adcsc_top dut (
        .pclk             (pclk),
        .presetn          (presetn),
        .apb_req          (apb_req),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .sar_result       (sar_result),
        .rc_tick          (rc_tick),
        .sleep_req        (sleep_req),
        .compare_mode_sel (compare_mode_sel),
        .special_trigger  (special_trigger),
        .port_pins        (port_pins),
        .analog           (analog),
        .wake_req         (wake_req),
        .timer_clear      (timer_clear)
    );

    always #2.5 pclk = ~pclk;

    // rc tick every 8 pclk; wake pulse is one cycle, so latch it
    always @(posedge pclk) begin
        rc_cnt  <= rc_cnt + 3'h1;
        rc_tick <= (rc_cnt == 3'h7);
        if (wake_req === 1'b1) woke <= 1'b1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, wr, {2'b00, idx, 2'b00}, {24'h00_0000, d}};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        // look at pready mid-cycle where it is settled, release at the edge that samples it
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) num_errors++;
        rd_val = prdata;
        err_seen = pslverr;
        @(posedge pclk);
        apb_req <= '0;
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(rd_val, exp);
    endtask

    // poll go until clear, then let the hold period run out
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            xfer(1'b0, `ADCSC_IDX_CTRL, 8'h00);
            n++;
        end while (rd_val[2] !== 1'b0 && n < 250);
        if (rd_val[2] !== 1'b0) num_errors++;
        repeat (160) @(posedge pclk);
    endtask

    task automatic pulse_trig();
        @(posedge pclk);
        special_trigger <= 1'b1;
        @(posedge pclk);
        special_trigger <= 1'b0;
        #1;
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`ADCSC_IDX_CTRL, 32'h00);
        rd_chk(`ADCSC_IDX_PORT, 32'h00);
        xfer(1'b0, 8'h01, 8'h00);
        chk({31'h0, err_seen}, 32'h01);
        xfer(1'b1, `ADCSC_IDX_CFG, 8'h04);
        rd_chk(`ADCSC_IDX_PORT, 32'h50);
        // left-justified, no acquisition, 2 pclk per period
        xfer(1'b1, `ADCSC_IDX_CFG, 8'h00);
        xfer(1'b1, `ADCSC_IDX_CTRL, 8'h01);
        xfer(1'b1, `ADCSC_IDX_CTRL, 8'h05);
        wait_idle();
        chk({31'h0, analog.sample_connect}, 32'h01);
        rd_chk(`ADCSC_IDX_RES_HI, 32'hb5);
        rd_chk(`ADCSC_IDX_RES_LO, 32'h40);
        rd_chk(`ADCSC_IDX_IRQ_FLAGS, 32'h40);
        // right-justified with acquisition code 010
        xfer(1'b1, `ADCSC_IDX_CFG, 8'h80);
        xfer(1'b1, `ADCSC_IDX_ACQ, 8'h10);
        xfer(1'b1, `ADCSC_IDX_CTRL, 8'h05);
        wait_idle();
        rd_chk(`ADCSC_IDX_RES_LO, 32'hd5);
        // slow clock code 110, abort mid-conversion
        xfer(1'b1, `ADCSC_IDX_IRQ_FLAGS, 8'h00);
        xfer(1'b1, `ADCSC_IDX_ACQ, 8'h00);
        sar_result <= 10'h133;
        xfer(1'b1, `ADCSC_IDX_CFG, 8'hc0);
        xfer(1'b1, `ADCSC_IDX_CTRL, 8'h81);
        xfer(1'b1, `ADCSC_IDX_CTRL, 8'h85);
        repeat (40) @(posedge pclk);
        chk({31'h0, analog.converting}, 32'h01);
        xfer(1'b1, `ADCSC_IDX_CTRL, 8'h81);
        rd_chk(`ADCSC_IDX_CTRL, 32'h81);
        rd_chk(`ADCSC_IDX_RES_LO, 32'hd5);
        rd_chk(`ADCSC_IDX_IRQ_FLAGS, 32'h00);
        wait_idle();
        // sleep with a non-rc clock aborts, on bit stays
        xfer(1'b1, `ADCSC_IDX_CTRL, 8'h85);
        repeat (40) @(posedge pclk);
        sleep_req <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({31'h0, analog.powered}, 32'h00);
        rd_chk(`ADCSC_IDX_CTRL, 32'h81);
        sleep_req <= 1'b0;
        wait_idle();
        // rc clock conversion in sleep wakes the core
        xfer(1'b1, `ADCSC_IDX_IRQ_EN, 8'h40);
        xfer(1'b1, `ADCSC_IDX_CFG, 8'h80);
        xfer(1'b1, `ADCSC_IDX_CTRL, 8'hc1);
        xfer(1'b1, `ADCSC_IDX_CTRL, 8'hc5);
        sleep_req <= 1'b1;
        wait_idle();
        chk({31'h0, woke}, 32'h01);
        rd_chk(`ADCSC_IDX_RES_LO, 32'h33);
        sleep_req <= 1'b0;
        // compare trigger with converter off, then on
        xfer(1'b1, `ADCSC_IDX_CTRL, 8'h00);
        pulse_trig();
        chk({31'h0, timer_clear}, 32'h01);
        rd_chk(`ADCSC_IDX_CTRL, 32'h00);
        // other compare modes neither start nor clear the timer
        compare_mode_sel <= 4'h0;
        xfer(1'b1, `ADCSC_IDX_CTRL, 8'h01);
        pulse_trig();
        chk({31'h0, timer_clear}, 32'h00);
        rd_chk(`ADCSC_IDX_CTRL, 32'h01);
        compare_mode_sel <= 4'hb;
        xfer(1'b1, `ADCSC_IDX_CTRL, 8'h01);
        repeat (160) @(posedge pclk);
        pulse_trig();
        chk({31'h0, timer_clear}, 32'h01);
        rd_chk(`ADCSC_IDX_CTRL, 32'h05);
        wait_idle();
        end_of_test();
    end

    // hang guard, well past the longest expected run
    initial begin
        #60000;
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
